// ==== aso_alu_top.sv ====
`timescale 1ns/10ps
module aso_alu_top (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Instruction from the decoder.
    input wire logic instr_valid,
    input wire logic [aso_pkg::ASO_OPC_W-1:0] instr,
    // Content of the file register addressed by the instruction.
    input wire logic [aso_pkg::ASO_DATA_W-1:0] file_rdata,
    // Write port toward the register file.
    output logic file_we,
    output logic [aso_pkg::ASO_FADDR_W-1:0] file_addr,
    output logic [aso_pkg::ASO_DATA_W-1:0] file_wdata,
    // Architectural state.
    output logic [aso_pkg::ASO_DATA_W-1:0] work,
    output logic carry,
    output logic digit_carry_flag,
    output logic zero,
    output logic [aso_pkg::ASO_PTR_W-1:0] ptr0,
    output logic [aso_pkg::ASO_PTR_W-1:0] ptr1,
    output logic exec_done,
    // Software register port.
    input wire logic [aso_pkg::ASO_BUS_AW-1:0] bus_addr,
    input wire logic [aso_pkg::ASO_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [aso_pkg::ASO_DATA_W-1:0] bus_rdata
);
    import aso_pkg::*;

    // ************************************************************
    // Declarations.
    // ************************************************************

    // State and decode.
    aso_state_type s;       // Registered state of the whole block.
    aso_state_type next_s;  // Next value of the state.
    aso_op_type op_kind;    // Decoded operation of this cycle.
    aso_alu_if alu ();      // Bundle toward the ALU core.

    // Instruction fields.
    logic [ASO_LIT6_W-1:0] lit6;         // Signed pointer literal.
    logic [ASO_PTR_W-1:0] lit6_ext;      // Literal sign-extended to pointer width.
    logic [ASO_DATA_W-1:0] lit8;         // Unsigned byte literal.
    logic [ASO_FADDR_W-1:0] faddr;       // File address field.
    logic dest_file;                     // Destination select bit.
    logic ptr_sel;                       // Pointer select bit.
    logic [ASO_DATA_W-1:0] status_byte;  // Status flags as read by software.

    // ************************************************************
    // Field extraction.
    // ************************************************************

    // Fields are cut out unconditionally; only the decoded kind decides use.
    always_comb begin
        lit6 = instr[ASO_LIT6_MSB:0];
        lit6_ext = {{(ASO_PTR_W-ASO_LIT6_W){lit6[ASO_LIT6_W-1]}}, lit6};
        lit8 = instr[ASO_LIT8_MSB:0];
        faddr = instr[ASO_FADDR_MSB:0];
        dest_file = instr[ASO_DEST_BIT];
        ptr_sel = instr[ASO_PTR_SEL_BIT];
    end

    // ************************************************************
    // Instruction decode.
    // ************************************************************

    // Anything outside the handled prefixes is ignored and changes nothing.
    always_comb begin
        op_kind = ASO_OP_NONE;
        if (instr_valid) begin
            if (instr[ASO_OPC_MSB:ASO_PFX7_LSB] == ASO_PFX_PTR_ADD) begin
                op_kind = ASO_OP_PTR_ADD;
            end else begin
                unique case (instr[ASO_OPC_MSB:ASO_PFX6_LSB])
                    ASO_PFX_AND_IMM: begin
                        op_kind = ASO_OP_AND_IMM;
                    end
                    ASO_PFX_ADD_IMM: begin
                        op_kind = ASO_OP_ADD_IMM;
                    end
                    ASO_PFX_AND_FILE: begin
                        op_kind = ASO_OP_AND_FILE;
                    end
                    ASO_PFX_ADD_FILE: begin
                        op_kind = ASO_OP_ADD_FILE;
                    end
                    ASO_PFX_ADDC_FILE: begin
                        op_kind = ASO_OP_ADDC_FILE;
                    end
                    ASO_PFX_ASR_FILE: begin
                        op_kind = ASO_OP_ASR_FILE;
                    end
                    default: begin
                        // Not an operation of this unit.
                        op_kind = ASO_OP_NONE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Operand steering toward the ALU core.
    // ************************************************************

    // The working register is always operand a; b is the literal or the file.
    always_comb begin
        // Defaults first.
        alu.a = s.work;
        alu.b = file_rdata;
        alu.cin = 1'b0;
        alu.fn = ASO_FN_AND;
        unique case (op_kind)
            ASO_OP_AND_IMM: begin
                alu.b = lit8;
            end
            ASO_OP_ADD_IMM: begin
                alu.b = lit8;
                alu.fn = ASO_FN_ADD;
            end
            ASO_OP_ADD_FILE: begin
                alu.fn = ASO_FN_ADD;
            end
            ASO_OP_ADDC_FILE: begin
                alu.fn = ASO_FN_ADD;
                alu.cin = s.carry;
            end
            ASO_OP_ASR_FILE: begin
                alu.fn = ASO_FN_ASR;
            end
            default: begin
                // AND with the file, pointer add and idle use the defaults.
                alu.fn = ASO_FN_AND;
            end
        endcase
    end

    // One ALU core serves every byte operation.
    aso_alu_core u_core (
        .alu(alu.core)
    );

    // ************************************************************
    // Next-state logic.
    // ************************************************************

    // Status byte as software sees it; upper bits read as zero.
    always_comb begin
        status_byte = '0;
        status_byte[ASO_ST_C_BIT] = s.carry;
        status_byte[ASO_ST_DC_BIT] = s.digit_carry_flag;
        status_byte[ASO_ST_Z_BIT] = s.zero;
    end

    // Software writes are applied first and an instruction that touches the
    // same state in the same cycle overrides them, so execution never stalls.
    always_comb begin
        // State holds unless written below.
        next_s = s;
        next_s.file_we = 1'b0;
        next_s.done = 1'b0;
        next_s.rdata = '0;

        // Read data exist only in the cycle after the read strobe.
        if (bus_rd) begin
            unique case (bus_addr)
                ASO_REG_WORK: begin
                    next_s.rdata = s.work;
                end
                ASO_REG_STATUS: begin
                    next_s.rdata = status_byte;
                end
                ASO_REG_PTR0_LO: begin
                    next_s.rdata = s.ptr0[ASO_DATA_W-1:0];
                end
                ASO_REG_PTR0_HI: begin
                    next_s.rdata = s.ptr0[ASO_PTR_W-1:ASO_DATA_W];
                end
                ASO_REG_PTR1_LO: begin
                    next_s.rdata = s.ptr1[ASO_DATA_W-1:0];
                end
                ASO_REG_PTR1_HI: begin
                    next_s.rdata = s.ptr1[ASO_PTR_W-1:ASO_DATA_W];
                end
                default: begin
                    // Unmapped addresses read as zero.
                    next_s.rdata = '0;
                end
            endcase
        end

        // Software loads of the architectural state.
        if (bus_wr) begin
            unique case (bus_addr)
                ASO_REG_WORK: begin
                    next_s.work = bus_wdata;
                end
                ASO_REG_STATUS: begin
                    next_s.carry = bus_wdata[ASO_ST_C_BIT];
                    next_s.digit_carry_flag = bus_wdata[ASO_ST_DC_BIT];
                    next_s.zero = bus_wdata[ASO_ST_Z_BIT];
                end
                ASO_REG_PTR0_LO: begin
                    next_s.ptr0[ASO_DATA_W-1:0] = bus_wdata;
                end
                ASO_REG_PTR0_HI: begin
                    next_s.ptr0[ASO_PTR_W-1:ASO_DATA_W] = bus_wdata;
                end
                ASO_REG_PTR1_LO: begin
                    next_s.ptr1[ASO_DATA_W-1:0] = bus_wdata;
                end
                ASO_REG_PTR1_HI: begin
                    next_s.ptr1[ASO_PTR_W-1:ASO_DATA_W] = bus_wdata;
                end
                default: begin
                    // Writes to unmapped addresses are dropped.
                    next_s.rdata = next_s.rdata;
                end
            endcase
        end

        // Execution; every handled instruction completes in this one cycle.
        if (op_kind == ASO_OP_PTR_ADD) begin
            // The 16-bit sum drops its carry, so the pair wraps both ways;
            // no flag is written.
            if (ptr_sel) begin
                next_s.ptr1 = s.ptr1 + lit6_ext;
            end else begin
                next_s.ptr0 = s.ptr0 + lit6_ext;
            end
            next_s.done = 1'b1;
        end else if (op_kind != ASO_OP_NONE) begin
            next_s.zero = alu.z_out;
            if (alu.upd_c) begin
                next_s.carry = alu.c_out;
            end
            if (alu.upd_dc) begin
                next_s.digit_carry_flag = alu.dc_out;
            end
            if (op_kind == ASO_OP_AND_IMM || op_kind == ASO_OP_ADD_IMM) begin
                next_s.work = alu.result;
            end else if (dest_file) begin
                // Result goes back to the addressed file register.
                next_s.file_we = 1'b1;
                next_s.file_addr = faddr;
                next_s.file_wdata = alu.result;
            end else begin
                next_s.work = alu.result;
            end
            next_s.done = 1'b1;
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************

    // A low enable freezes everything, the pulses included, which keeps a
    // file write strobe alive for the stalled cycles; the register file
    // must run on the same enable.
    always_ff @(posedge clk or negedge rstn) begin
        // Reset loads constants only.
        if (!rstn) begin
            s <= ASO_STATE_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs, each straight from the state register.
    // ************************************************************

    // No logic between flop and pin.
    assign file_we = s.file_we;
    assign file_addr = s.file_addr;
    assign file_wdata = s.file_wdata;
    assign work = s.work;
    assign carry = s.carry;
    assign digit_carry_flag = s.digit_carry_flag;
    assign zero = s.zero;
    assign ptr0 = s.ptr0;
    assign ptr1 = s.ptr1;
    assign exec_done = s.done;
    assign bus_rdata = s.rdata;

endmodule

// ==== aso_pkg.sv ====
// ****************************************************************
// Shared constants and types of the add and shift unit.
// ****************************************************************
package aso_pkg;

    // ************************************************************
    // Widths.
    // ************************************************************
    localparam int ASO_DATA_W = 8;   // Working and file register width.
    localparam int ASO_PTR_W = 16;   // Indirect pointer pair width.
    localparam int ASO_LIT6_W = 6;   // Signed pointer literal width.
    localparam int ASO_OPC_W = 14;   // Instruction word width.
    localparam int ASO_FADDR_W = 7;  // File address width, 0 to 127.
    localparam int ASO_BUS_AW = 3;   // Register port address width.
    localparam int ASO_NIB_W = 4;    // Low nibble width for digit carry.

    // ************************************************************
    // Instruction word fields.
    // ************************************************************
    localparam int ASO_OPC_MSB = 13;     // Top bit of the instruction word.
    localparam int ASO_PFX7_LSB = 7;     // Low bit of the 7-bit pointer-add prefix.
    localparam int ASO_PFX6_LSB = 8;     // Low bit of the 6-bit prefix of other ops.
    localparam int ASO_PTR_SEL_BIT = 6;  // Pointer select bit n.
    localparam int ASO_DEST_BIT = 7;     // Destination select bit d.
    localparam int ASO_LIT6_MSB = 5;     // Top bit of the 6-bit literal.
    localparam int ASO_LIT8_MSB = 7;     // Top bit of the 8-bit literal.
    localparam int ASO_FADDR_MSB = 6;    // Top bit of the file address.

    // Opcode prefixes; the literal ones beside the pointer add are defaults.
    localparam logic [6:0] ASO_PFX_PTR_ADD = 7'h62;
    localparam logic [5:0] ASO_PFX_AND_IMM = 6'h39;
    localparam logic [5:0] ASO_PFX_ADD_IMM = 6'h3e;
    localparam logic [5:0] ASO_PFX_AND_FILE = 6'h05;
    localparam logic [5:0] ASO_PFX_ADD_FILE = 6'h07;
    localparam logic [5:0] ASO_PFX_ASR_FILE = 6'h37;
    localparam logic [5:0] ASO_PFX_ADDC_FILE = 6'h3d;

    // ************************************************************
    // Register port map and status bit positions.
    // ************************************************************
    localparam logic [2:0] ASO_REG_WORK = 3'h0;
    localparam logic [2:0] ASO_REG_STATUS = 3'h1;
    localparam logic [2:0] ASO_REG_PTR0_LO = 3'h2;
    localparam logic [2:0] ASO_REG_PTR0_HI = 3'h3;
    localparam logic [2:0] ASO_REG_PTR1_LO = 3'h4;
    localparam logic [2:0] ASO_REG_PTR1_HI = 3'h5;
    localparam int ASO_ST_C_BIT = 0;
    localparam int ASO_ST_DC_BIT = 1;
    localparam int ASO_ST_Z_BIT = 2;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [2:0] {
        ASO_OP_NONE, ASO_OP_PTR_ADD, ASO_OP_AND_IMM, ASO_OP_ADD_IMM,
        ASO_OP_AND_FILE, ASO_OP_ADD_FILE, ASO_OP_ADDC_FILE, ASO_OP_ASR_FILE
    } aso_op_type;

    typedef enum logic [1:0] {
        ASO_FN_AND, ASO_FN_ADD, ASO_FN_ASR
    } aso_func_type;

    typedef struct packed {
        logic [ASO_DATA_W-1:0] work;        // Working register.
        logic carry;                        // Carry flag.
        logic digit_carry_flag;             // Carry out of bit 3.
        logic zero;                         // Zero flag.
        logic [ASO_PTR_W-1:0] ptr0;         // Indirect pointer pair 0.
        logic [ASO_PTR_W-1:0] ptr1;         // Indirect pointer pair 1.
        logic file_we;                      // File write strobe.
        logic [ASO_FADDR_W-1:0] file_addr;  // File write address.
        logic [ASO_DATA_W-1:0] file_wdata;  // File write data.
        logic done;                         // Execution pulse.
        logic [ASO_DATA_W-1:0] rdata;       // Register port read data.
    } aso_state_type;

    localparam aso_state_type ASO_STATE_RST = '0;

endpackage

// ==== aso_alu_if.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Operand and result bundle between the sequencer and the ALU core.
// ****************************************************************
interface aso_alu_if;
    import aso_pkg::*;
    aso_func_type fn;                // Selected function.
    logic [ASO_DATA_W-1:0] a;        // Working register operand.
    logic [ASO_DATA_W-1:0] b;        // Literal or file operand.
    logic cin;                       // Carry in, zero for plain adds.
    logic [ASO_DATA_W-1:0] result;   // Eight-bit result.
    logic c_out;                     // New carry.
    logic dc_out;                    // New digit carry.
    logic z_out;                     // New zero.
    logic upd_c;                     // Carry is to be written.
    logic upd_dc;                    // Digit carry is to be written.
    modport core (input fn, a, b, cin, output result, c_out, dc_out, z_out, upd_c, upd_dc);
    modport user (output fn, a, b, cin, input result, c_out, dc_out, z_out, upd_c, upd_dc);
endinterface

// ==== aso_alu_core.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Eight-bit AND, add and arithmetic shift with flag results.
// ****************************************************************
module aso_alu_core (
    // Operand and result bundle.
    aso_alu_if.core alu
);
    import aso_pkg::*;

    logic [ASO_DATA_W:0] sum;     // Nine-bit sum holding the carry out.
    logic [ASO_NIB_W:0] nib_sum;  // Low nibble sum holding the digit carry.

    // Pure combinational; the zero flag is always derived from the result.
    always_comb begin
        sum = {1'b0, alu.a} + {1'b0, alu.b} + {{ASO_DATA_W{1'b0}}, alu.cin};
        nib_sum = {1'b0, alu.a[ASO_NIB_W-1:0]} + {1'b0, alu.b[ASO_NIB_W-1:0]}
                + {{ASO_NIB_W{1'b0}}, alu.cin};
        alu.result = '0;
        alu.c_out = 1'b0;
        alu.dc_out = 1'b0;
        alu.upd_c = 1'b0;
        alu.upd_dc = 1'b0;
        unique case (alu.fn)
            ASO_FN_AND: begin
                alu.result = alu.a & alu.b;
            end
            ASO_FN_ADD: begin
                // Carry from bit 7, digit carry from bit 3.
                alu.result = sum[ASO_DATA_W-1:0];
                alu.c_out = sum[ASO_DATA_W];
                alu.dc_out = nib_sum[ASO_NIB_W];
                alu.upd_c = 1'b1;
                alu.upd_dc = 1'b1;
            end
            ASO_FN_ASR: begin
                // The sign bit is kept and bit 0 falls into carry.
                alu.result = {alu.b[ASO_DATA_W-1], alu.b[ASO_DATA_W-1:1]};
                alu.c_out = alu.b[0];
                alu.upd_c = 1'b1;
            end
            default: begin
                // An unused function code gives a zero result and asks for no carry update.
                alu.result = '0;
            end
        endcase
        alu.z_out = (alu.result == '0);
    end

endmodule

// ==== aso_alu_monitor.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Port checker of the add and shift unit.
// ****************************************************************
module aso_alu_monitor (
    // Clock and control.
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Instruction side.
    input wire logic instr_valid,
    input wire logic [aso_pkg::ASO_OPC_W-1:0] instr,
    input wire logic [aso_pkg::ASO_DATA_W-1:0] file_rdata,
    input wire logic file_we,
    input wire logic [aso_pkg::ASO_FADDR_W-1:0] file_addr,
    input wire logic [aso_pkg::ASO_DATA_W-1:0] file_wdata,
    // Architectural state.
    input wire logic [aso_pkg::ASO_DATA_W-1:0] work,
    input wire logic carry,
    input wire logic digit_carry_flag,
    input wire logic zero,
    input wire logic [aso_pkg::ASO_PTR_W-1:0] ptr0,
    input wire logic [aso_pkg::ASO_PTR_W-1:0] ptr1,
    input wire logic exec_done,
    // Register port.
    input wire logic [aso_pkg::ASO_BUS_AW-1:0] bus_addr,
    input wire logic [aso_pkg::ASO_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [aso_pkg::ASO_DATA_W-1:0] bus_rdata
);
    import aso_pkg::*;
    // A same-cycle software write could move the flags.
    wire go = ce && instr_valid && !bus_wr;
    wire [5:0] pfx = instr[13:8];
    wire ptr_op = go && instr[13:7] == ASO_PFX_PTR_ADD;
    wire and_i = go && pfx == ASO_PFX_AND_IMM;
    wire add_i = go && pfx == ASO_PFX_ADD_IMM;
    wire and_f = go && pfx == ASO_PFX_AND_FILE;
    wire add_f = go && (pfx == ASO_PFX_ADD_FILE || pfx == ASO_PFX_ADDC_FILE);
    wire asr_f = go && pfx == ASO_PFX_ASR_FILE;
    wire cin = (pfx == ASO_PFX_ADDC_FILE) && carry;
    // Reference results, sampled one cycle later.
    wire [15:0] ptr_sum = (instr[6] ? ptr1 : ptr0) + {{10{instr[5]}}, instr[5:0]};
    wire [8:0] sum_i = work + instr[7:0];
    wire [8:0] sum_f = work + file_rdata + cin;
    wire dc_i = (work[3:0] + instr[3:0]) > 5'hf;
    wire dc_f = (work[3:0] + file_rdata[3:0] + cin) > 5'hf;
    wire [7:0] and_r = work & (and_i ? instr[7:0] : file_rdata);
    wire [8:0] asr_x = {file_rdata[7], file_rdata};
    wire [7:0] res = file_we ? file_wdata : work;
    wire [6:0] f_adr = instr[6:0];
    wire n_sel = instr[6];
    wire d_bit = instr[7];
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ptr_flags_kept: assert property (ptr_op |=> exec_done
        && $stable({carry, digit_carry_flag, zero}))
        else $error("flags moved on pointer add");
    a_ptr_sum_wrap: assert property (ptr_op |=> ($past(n_sel) ? ptr1 : ptr0) == $past(ptr_sum))
        else $error("pointer sum wrong");
    a_and_imm_zero: assert property (and_i |=> work == $past(and_r) && zero == (work == 8'h00)
        && $stable(carry))
        else $error("literal and wrong");
    a_add_imm_flags: assert property (add_i |=> {carry, work} == $past(sum_i)
        && digit_carry_flag == $past(dc_i))
        else $error("literal add wrong");
    a_file_dest_sel: assert property ((and_f || add_f || asr_f) |=> file_we == $past(d_bit)
        && (!file_we || file_addr == $past(f_adr)))
        else $error("destination select wrong");
    a_and_file_zero: assert property (and_f |=> res == $past(and_r) && zero == (res == 8'h00))
        else $error("file and wrong");
    a_add_file_sum: assert property (add_f |=> {carry, res} == $past(sum_f)
        && digit_carry_flag == $past(dc_f))
        else $error("file add wrong");
    a_asr_sign_kept: assert property (asr_f |=> {res, carry} == $past(asr_x)
        && zero == (res == 8'h00))
        else $error("shift wrong");
    a_zero_on_add: assert property ((add_i || add_f) |=> zero == ((add_i ? work : res) == 8'h00))
        else $error("zero flag wrong");
endmodule

bind aso_alu_top aso_alu_monitor u_aso_alu_monitor (
    .clk(clk), .rstn(rstn), .ce(ce), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
    .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata), .work(work), .carry(carry),
    .digit_carry_flag(digit_carry_flag), .zero(zero), .ptr0(ptr0), .ptr1(ptr1), .exec_done(exec_done),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
);

// ==== tb_add_and_shift_alu_ops.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench of the add and shift unit.
// ****************************************************************
module tb_add_and_shift_alu_ops;
    import aso_pkg::*;
    // A row: inputs and flags, then what they give.
    typedef struct packed {
        logic [13:0] op;
        logic [7:0] w0;
        logic [2:0] st0;
        logic [7:0] f;
        logic [7:0] res;
        logic [2:0] st1;
        logic wf;
    } aso_row_type;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic instr_valid = 1'b0;
    logic [13:0] instr = '0;
    logic [7:0] file_rdata = '0;
    logic [2:0] bus_addr = '0;
    logic [7:0] bus_wdata = '0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic file_we, carry, digit_carry_flag, zero, exec_done;
    logic [6:0] file_addr;
    logic [7:0] file_wdata, work, bus_rdata;
    logic [15:0] ptr0, ptr1;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    wire [2:0] st = {zero, digit_carry_flag, carry};
    // Flags are {zero, digit carry, carry}; rows sit at the carry edges.
    aso_row_type rows [15] = '{
        '{14'h390f, 8'hf0, 3'h3, 8'h00, 8'h00, 3'h7, 1'b0}, '{14'h393c, 8'hff, 3'h4, 8'h00, 8'h3c, 3'h0, 1'b0},
        '{14'h3e01, 8'hff, 3'h0, 8'h00, 8'h00, 3'h7, 1'b0}, '{14'h3e08, 8'h08, 3'h7, 8'h00, 8'h10, 3'h2, 1'b0},
        '{14'h3e80, 8'h90, 3'h0, 8'h00, 8'h10, 3'h1, 1'b0}, '{14'h057f, 8'haa, 3'h3, 8'h0f, 8'h0a, 3'h3, 1'b0},
        '{14'h0580, 8'h55, 3'h0, 8'haa, 8'h00, 3'h4, 1'b1}, '{14'h0785, 8'h7f, 3'h1, 8'h01, 8'h80, 3'h2, 1'b1},
        '{14'h0740, 8'hc8, 3'h0, 8'h38, 8'h00, 3'h7, 1'b0}, '{14'h3d11, 8'h0f, 3'h1, 8'h00, 8'h10, 3'h2, 1'b0},
        '{14'h3dff, 8'hff, 3'h1, 8'h00, 8'h00, 3'h7, 1'b1}, '{14'h3d22, 8'h01, 3'h6, 8'h02, 8'h03, 3'h0, 1'b0},
        '{14'h3701, 8'h00, 3'h0, 8'h81, 8'hc0, 3'h1, 1'b0}, '{14'h37ff, 8'h00, 3'h2, 8'h01, 8'h00, 3'h7, 1'b1},
        '{14'h3790, 8'h00, 3'h5, 8'h7e, 8'h3f, 3'h0, 1'b1}};

    aso_alu_top u_aso_alu_top (
        .clk(clk), .rstn(rstn), .ce(ce), .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
        .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata), .work(work), .carry(carry),
        .digit_carry_flag(digit_carry_flag), .zero(zero), .ptr0(ptr0), .ptr1(ptr1), .exec_done(exec_done),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));

    // ****************************************************************
    // Clock, watchdog and shared tasks.
    // ****************************************************************
    initial begin
        forever #5 clk = ~clk;
    end

    // A hang ends the run as a failure.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic bwr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    // Read data stand one cycle; the idle cycle after is checked too.
    task automatic brd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 chk("rdata", e, bus_rdata);
        @(posedge clk);
        #1 chk("rdata idle", 0, bus_rdata);
    endtask

    // Up to two instructions back to back; outputs are settled on return.
    task automatic ex(input logic [13:0] op, input logic [7:0] f, input logic [13:0] op2, input logic two);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= op;
        file_rdata <= f;
        if (two) begin
            @(posedge clk);
            instr <= op2;
        end
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic results();
        if (n_fail == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            bwr(ASO_REG_WORK, rows[i].w0);
            bwr(ASO_REG_STATUS, {5'h0, rows[i].st0});
            ex(rows[i].op, rows[i].f, 14'h0, 1'b0);
            chk("done", 1, exec_done);
            chk("file_we", rows[i].wf, file_we);
            chk("res", rows[i].res, rows[i].wf ? file_wdata : work);
            chk("flags", rows[i].st1, st);
            if (rows[i].wf) begin
                chk("file_addr", rows[i].op[6:0], file_addr);
                chk("work kept", rows[i].w0, work);
            end
        end
        // Pointer adds wrap both ways and leave the flags alone.
        bwr(ASO_REG_PTR0_LO, 8'hfe);
        bwr(ASO_REG_PTR0_HI, 8'hff);
        bwr(ASO_REG_PTR1_LO, 8'h10);
        bwr(ASO_REG_PTR1_HI, 8'h00);
        bwr(ASO_REG_STATUS, 8'h07);
        ex(14'h3103, 8'h00, 14'h3160, 1'b1);
        chk("ptr0", 16'h0001, ptr0);
        chk("ptr1", 16'hfff0, ptr1);
        chk("flags", 3'h7, st);
        brd(ASO_REG_PTR1_HI, 8'hff);
        ex(14'h315f, 8'h00, 14'h313f, 1'b1);
        chk("ptr1", 16'h000f, ptr1);
        chk("ptr0", 16'h0000, ptr0);
        // Back-to-back adds each see the previous sum.
        bwr(ASO_REG_WORK, 8'h10);
        ex(14'h3e20, 8'h00, 14'h3e30, 1'b1);
        chk("work", 8'h60, work);
        // An unhandled opcode and a frozen clock enable change nothing.
        ex(14'h3800, 8'h00, 14'h0, 1'b0);
        chk("done", 0, exec_done);
        @(posedge clk);
        ce <= 1'b0;
        ex(14'h3e01, 8'h00, 14'h0, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        #1 chk("work", 8'h60, work);
        bwr(3'h7, 8'h55);
        brd(3'h7, 8'h00);
        brd(ASO_REG_WORK, 8'h60);
        // A second reset in mid-run clears the state.
        @(posedge clk);
        rstn <= 1'b0;
        #1 chk("reset work", 0, work);
        chk("reset ptr1", 0, ptr1);
        chk("reset flags", 0, st);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        brd(ASO_REG_PTR1_LO, 8'h00);
        results();
    end
endmodule
